// File: dv/boot_select_isp_frame_test.sv
`timescale 1ns/10ps
module boot_select_isp_frame_test;
  import boot_select_pkg::*;
  logic clk = 0, srst = 1, ext = 0, reset_polarity_select = 1, strobe = 1, jump = 1, rdy = 0, wr = 0, crx = 1, eap = 1;
  logic [7:0] status = 8'hff, vec = 8'hfc, wdata = 8'hff;
  logic [2:0] lk = 3'b011;
  logic rxd, txd, valid, done, err, bv, ds, srcb, ramen, fetch, eao, ovr;
  logic [7:0] shadow, swb;
  boot_mode_t mode;
  logic [15:0] addr;
  hw_lock_t hw;
  sw_lock_t sw;
  prog_word_t word;
  int num_errors = 0, n_checks = 0, n_done = 0, n_err = 0;
  string f1 = ":02001000AA55EF";
  always #2 clk = ~clk;
  host_uart_model #(.BIT_CYC(16)) host (.core_clk_i(clk), .rxd_o(rxd), .txd_i(txd));
  boot_select_isp_frame dut (.core_clk_i(clk), .srst_i(srst), .ext_reset_pin_i(ext),
    .reset_polarity_select_i(reset_polarity_select), .boot_force_strobe_pin_i(strobe), .external_access_pin_i(eap),
    .clock_doubling_fuse_i(lk[2]), .boot_jump_fuse_i(jump), .clock_source_fuse_i(lk[1]),
    .expanded_data_ram_fuse_i(lk[0]), .hardware_lock_bits_i(lk), .boot_status_byte_i(status),
    .soft_boot_vector_i(vec), .code_read_from_ext_i(crx), .sw_lock_wr_i(wr), .sw_lock_wdata_i(wdata),
    .uart_rxd_i(rxd), .word_ready_i(rdy), .boot_valid_o(bv), .boot_mode_o(mode), .boot_addr_o(addr),
    .hardware_fuse_shadow_o(shadow), .software_lock_byte_o(swb), .double_speed_o(ds),
    .clock_source_b_o(srcb), .expanded_ram_enable_o(ramen), .hw_lock_o(hw), .sw_lock_o(sw),
    .internal_fetch_allow_o(fetch), .external_access_o(eao), .uart_txd_o(txd), .word_valid_o(valid),
    .word_o(word), .frame_done_o(done), .frame_error_o(err), .overrun_o(ovr));
  // frame pulses last one cycle, so count them as they pass
  always @(posedge clk) begin
    n_done <= n_done + int'(done === 1'b1);
    n_err  <= n_err + int'(err === 1'b1);
  end
  task chk(input string n, input logic [39:0] got, input logic [39:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  task close_out();
    if (num_errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out
  // hold external reset, release it, then move the strobe: only the edge counts
  task rel(input logic p, s, j, input logic [7:0] st, v, input logic [2:0] l, input logic [1:0] em,
           input logic [15:0] ea);
    @(negedge clk);
    // fuse pins follow the lock pattern, so the first and last calls, both 3'b011, drive those three fuses alike
    {reset_polarity_select, ext, strobe, jump, status, vec, lk, crx, eap} = {p, p, s, j, st, v, l, l[0], 1'b1};
    repeat (2) @(negedge clk);
    ext = ~p;
    @(negedge clk);
    {strobe, eap} = {~s, 1'b0};
    @(negedge clk);
    chk("valid", bv, 1'b1);
    chk("mode", mode, em);
    chk("addr", addr, ea);
    chk("shadow", shadow, {l[2], j, l[1], 1'b0, l[0], l});
    chk("fuses", {ds, srcb, ramen}, {~l[2], ~l[1], l[0]});
    chk("hwlock", hw, {l != 3'b111, ~l[1] | ~l[2], ~l[2]});
    chk("fetch", fetch, !(l != 3'b111 && l[0]));
    chk("extacc", eao, l != 3'b111);
  endtask : rel
  task send_str(input string s);
    for (int i = 0; i < s.len(); i++) host.send_char(s[i]);
  endtask : send_str
  task wait_rx(input int n);
    for (int i = 0; i < 40000 && host.rxq.size() < n; i++) @(negedge clk);
  endtask : wait_rx
  task sw_write(input logic [7:0] d, input logic [7:0] eb, input logic [1:0] el);
    @(negedge clk);
    {wr, wdata} = {1'b1, d};
    @(negedge clk);
    wr = 1'b0;
    @(negedge clk);
    chk("swbyte", swb, eb);
    chk("swlock", sw, el);
  endtask : sw_write
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    close_out();
  end
  initial begin
    repeat (3) @(negedge clk);
    srst = 0;
    chk("swreset", swb, 8'hff);
    rel(1, 0, 1, 8'hff, 8'h12, 3'b011, BOOT_ROM, 16'hf800);
    rel(0, 1, 1, 8'hff, 8'h12, 3'b110, BOOT_APP, 16'h0000);
    rel(1, 1, 0, 8'h00, 8'h12, 3'b101, BOOT_APP, 16'h0000);
    rel(1, 1, 0, 8'hff, 8'h12, 3'b111, BOOT_CUSTOMER, 16'h1200);
    rel(1, 1, 0, 8'hff, 8'hfc, 3'b011, BOOT_ROM, 16'hf800);
    host.send_char(8'h55);
    send_str({"zz", f1});
    wait_rx(17);
    for (int i = 0; i < 15; i++) chk("echo", host.rxq[i + 2], f1[i]);
    chk("done", {n_done[3:0], n_err[3:0]}, 8'h10);
    // consumer stalled: both words wait in the buffer
    chk("word0", {valid, word}, {1'b1, 16'h0010, 8'h00, 8'haa});
    @(negedge clk) rdy = 1;
    @(negedge clk) rdy = 0;
    chk("word1", {valid, word}, {1'b1, 16'h0011, 8'h00, 8'h55});
    @(negedge clk) rdy = 1;
    @(negedge clk);
    chk("empty", valid, 1'b0);
    host.rxq.delete();
    send_str(":01001000559B");
    wait_rx(16);
    chk("bad", n_err, 1);
    chk("xcrlf", {host.rxq[13], host.rxq[14], host.rxq[15]}, 24'h580d0a);
    sw_write(8'hfe, 8'hfe, 2'b10);
    sw_write(8'hfc, 8'hfc, 2'b11);
    chk("overrun", ovr, 1'b0);
    close_out();
  end
endmodule : boot_select_isp_frame_test

// File: dv/host_uart_model.sv
`timescale 1ns/10ps
module host_uart_model #(
  parameter int BIT_CYC = 16
) (
  input  wire logic core_clk_i,
  output logic      rxd_o,
  input  wire logic txd_i
);
  logic [7:0] rxq[$];
  // line idles high between characters
  initial rxd_o = 1'b1;
  // start, 8 data lsb first, 2 stop; one extra idle bit so echoes never pile up
  task automatic send_char(input logic [7:0] c);
    logic [10:0] f;
    f = {2'b11, c, 1'b0};
    for (int i = 0; i < 12; i++) begin
      rxd_o = (i < 11) ? f[i] : 1'b1;
      repeat (BIT_CYC) @(negedge core_clk_i);
    end
  endtask : send_char
  // capture what comes back, sampled mid-bit
  always begin
    logic [7:0] b;
    @(negedge txd_i);
    repeat (BIT_CYC + BIT_CYC / 2) @(posedge core_clk_i);
    for (int i = 0; i < 8; i++) begin
      b[i] = txd_i;
      repeat (BIT_CYC) @(posedge core_clk_i);
    end
    rxq.push_back(b);
  end
endmodule : host_uart_model

// File: verilog/boot_select_isp_frame.sv
// Operation
// - strobe low at release forces ROM loader
// - release edge follows the polarity select
// - strobe sampled only at the release edge
// - forced boot ignores fuse, status, vector
// - jump fuse 1 application, 0 defers to status, vector
// - application at 0000h, loader at F800h
// - vector byte plus 00h, FCh means none
// - shadow byte mirrors the selected fuses
// - doubling fuse 0 gives double speed
// - programmed source fuse starts oscillator B
// - programmed ram fuse inhibits expanded ram
// - level 2 blocks internal reads from external code, parallel programming
// - level 3 also blocks parallel verify
// - level 4 also forbids external execution
// - software lock bits block loader program, verify
// - eight data bits, no parity, two stops
// - baud rate measured from host character
// - frame fields in fixed hex order
// - frame starts with a colon
// - length counts data bytes between type and checksum
// - offset addresses data-program records only
// - byte sum through checksum is zero
// - checksum mismatch answers X, CR, LF
// - every character after the opening U is echoed
`timescale 1ns/10ps
`include "boot_select_params.svh"
module boot_select_isp_frame
  import boot_select_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter int DEPTH = 2
) (
  input  wire logic        core_clk_i,
  input  wire logic        srst_i,
  input  wire logic        ext_reset_pin_i,
  input  wire logic        reset_polarity_select_i,
  input  wire logic        boot_force_strobe_pin_i,
  input  wire logic        external_access_pin_i,
  input  wire logic        clock_doubling_fuse_i,
  input  wire logic        boot_jump_fuse_i,
  input  wire logic        clock_source_fuse_i,
  input  wire logic        expanded_data_ram_fuse_i,
  input  wire logic [2:0]  hardware_lock_bits_i,
  input  wire logic [7:0]  boot_status_byte_i,
  input  wire logic [7:0]  soft_boot_vector_i,
  input  wire logic        code_read_from_ext_i,
  input  wire logic        sw_lock_wr_i,
  input  wire logic [7:0]  sw_lock_wdata_i,
  input  wire logic        uart_rxd_i,
  input  wire logic        word_ready_i,
  output logic             boot_valid_o,
  output boot_mode_t       boot_mode_o,
  output logic [15:0]      boot_addr_o,
  output logic [7:0]       hardware_fuse_shadow_o,
  output logic [7:0]       software_lock_byte_o,
  output logic             double_speed_o,
  output logic             clock_source_b_o,
  output logic             expanded_ram_enable_o,
  output hw_lock_t         hw_lock_o,
  output sw_lock_t         sw_lock_o,
  output logic             internal_fetch_allow_o,
  output logic             external_access_o,
  output logic             uart_txd_o,
  output logic             word_valid_o,
  output prog_word_t       word_o,
  output logic             frame_done_o,
  output logic             frame_error_o,
  output logic             overrun_o
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  generate
    if (CNT_W < 4 || DEPTH < 2) begin : g_bad_params
      $error("boot_select_isp_frame: CNT_W must be >= 4 and DEPTH >= 2");
    end
  endgenerate

  // one nibble from an ascii hex digit, msb flags a valid digit
  function automatic logic [4:0] hex_val(input logic [7:0] c);
    hex_val = 5'h00;
    if (c >= `CH_DIG_0 && c <= `CH_DIG_9)
      hex_val = {1'b1, c[3:0]};
    else if ((c >= `CH_UP_A && c <= `CH_UP_F) || (c >= `CH_LO_A && c <= `CH_LO_F))
      hex_val = {1'b1, c[3:0] + `HEX_ALPHA_ADJ};
  endfunction : hex_val

  // entry choice; a forced boot wins over every stored byte
  function automatic boot_mode_t pick_boot(input logic force_n, input logic jump,
                                           input logic [7:0] status, input logic [7:0] vec);
    if (!force_n)
      pick_boot = BOOT_ROM;
    else if (jump)
      pick_boot = BOOT_APP;
    else if (status == `BOOT_STATUS_APP)
      pick_boot = BOOT_APP;
    else if (vec != `SOFT_VEC_NONE)
      pick_boot = BOOT_CUSTOMER;
    else
      pick_boot = BOOT_ROM;
  endfunction : pick_boot

  // reset release edge, polarity chosen by the select pin
  logic rst_active;
  logic rst_act_q;
  logic release_edge;
  assign rst_active   = reset_polarity_select_i ? ext_reset_pin_i : ~ext_reset_pin_i;
  assign release_edge = rst_act_q & ~rst_active;
  // held high through srst so a power-up with the pin idle still decides once
  always_ff @(posedge core_clk_i) begin
    if (srst_i)
      rst_act_q <= 1'b1;
    else
      rst_act_q <= rst_active;
  end

  // boot decision and fuse capture, only at the release edge
  logic [7:0] shadow;
  logic       access_latch;
  boot_mode_t next_mode;
  assign next_mode = pick_boot(boot_force_strobe_pin_i, boot_jump_fuse_i, boot_status_byte_i,
                               soft_boot_vector_i);
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      boot_mode_o  <= BOOT_NONE;
      boot_addr_o  <= `APP_START_ADDR;
      boot_valid_o <= 1'b0;
      shadow       <= `SHADOW_RESET;
      access_latch <= 1'b0;
    end else if (release_edge) begin
      boot_mode_o  <= next_mode;
      boot_valid_o <= 1'b1;
      case (next_mode)
        BOOT_CUSTOMER: boot_addr_o <= {soft_boot_vector_i, `SOFT_VEC_LOW};
        BOOT_APP:      boot_addr_o <= `APP_START_ADDR;
        default:       boot_addr_o <= `ROM_LOADER_ADDR;
      endcase
      shadow[`SHADOW_DBL_BIT]  <= clock_doubling_fuse_i;
      shadow[`SHADOW_JUMP_BIT] <= boot_jump_fuse_i;
      shadow[`SHADOW_SRC_BIT]  <= clock_source_fuse_i;
      shadow[`SHADOW_RSVD_BIT] <= 1'b0;
      shadow[`SHADOW_RAM_BIT]  <= expanded_data_ram_fuse_i;
      shadow[`HW_LOCK_B2:`HW_LOCK_B0] <= hardware_lock_bits_i;
      access_latch <= external_access_pin_i;
    end else if (rst_active) begin
      boot_valid_o <= 1'b0;
    end
  end

  // fuse effects; programmed means zero
  logic lvl2;
  logic lvl3;
  logic lvl4;
  assign hardware_fuse_shadow_o = shadow;
  assign double_speed_o         = ~shadow[`SHADOW_DBL_BIT];
  assign clock_source_b_o       = ~shadow[`SHADOW_SRC_BIT];
  assign expanded_ram_enable_o  = shadow[`SHADOW_RAM_BIT];
  assign lvl4 = ~shadow[`HW_LOCK_B2];
  assign lvl3 = lvl4 | ~shadow[`HW_LOCK_B1];
  assign lvl2 = lvl3 | ~shadow[`HW_LOCK_B0];
  assign hw_lock_o.parallel_prog_block   = lvl2;
  assign hw_lock_o.parallel_verify_block = lvl3;
  assign hw_lock_o.external_exec_block   = lvl4;
  assign internal_fetch_allow_o = ~(lvl2 & code_read_from_ext_i);
  assign external_access_o      = lvl2 ? access_latch : external_access_pin_i;

  // software lock byte: writes can only raise protection
  logic [7:0] sw_lock;
  always_ff @(posedge core_clk_i) begin
    if (srst_i)
      sw_lock <= `SW_LOCK_RESET;
    else if (sw_lock_wr_i)
      sw_lock <= sw_lock & (sw_lock_wdata_i | `SW_LOCK_RSVD); // reserved bits kept high
  end
  assign software_lock_byte_o          = sw_lock;
  assign sw_lock_o.loader_verify_block = ~sw_lock[`SW_LOCK_B1];
  assign sw_lock_o.loader_prog_block   = ~sw_lock[`SW_LOCK_B0] | ~sw_lock[`SW_LOCK_B1];

  // serial receiver with autobaud on the start bit of the opening U
  rx_state_t        rx_state;
  logic [CNT_W-1:0] bit_cycles;
  logic [CNT_W-1:0] rx_cnt;
  logic [2:0]       rx_nbit;
  logic [7:0]       rx_shift;
  logic             rx_evt;
  logic             loader_active;
  assign loader_active = boot_valid_o && (boot_mode_o == BOOT_ROM);
  always_ff @(posedge core_clk_i) begin
    if (srst_i || rst_active || !loader_active) begin
      rx_state   <= RX_BAUD;
      rx_cnt     <= '0;
      bit_cycles <= '0;
      rx_nbit    <= 3'h0;
      rx_shift   <= 8'h00;
      rx_evt     <= 1'b0;
    end else begin
      rx_evt <= 1'b0;
      case (rx_state)
        RX_BAUD: begin
          if (bit_cycles == '0) begin
            // first low stretch of the opening U is one bit time
            if (!uart_rxd_i && !(&rx_cnt))
              rx_cnt <= rx_cnt + 1'b1;
            else if (uart_rxd_i && rx_cnt != '0) begin
              bit_cycles <= rx_cnt;
              rx_cnt     <= '0;
            end
          // rest of the U has single high bits; only its stop bits stay high 1.5 bits, so it is never echoed
          end else if (!uart_rxd_i)
            rx_cnt <= '0;
          else if (rx_cnt == bit_cycles + (bit_cycles >> 1))
            rx_state <= RX_IDLE;
          else
            rx_cnt <= rx_cnt + 1'b1;
        end
        RX_IDLE: begin
          rx_cnt <= '0;
          if (!uart_rxd_i)
            rx_state <= RX_START;
        end
        RX_START: begin
          rx_cnt <= rx_cnt + 1'b1;
          if (rx_cnt == (bit_cycles >> 1)) begin
            rx_cnt   <= '0;
            rx_nbit  <= 3'h0;
            rx_state <= uart_rxd_i ? RX_IDLE : RX_BITS; // glitch filter on the start bit
          end
        end
        RX_BITS: begin
          rx_cnt <= rx_cnt + 1'b1;
          if (rx_cnt == bit_cycles - 1'b1) begin
            rx_cnt   <= '0;
            rx_shift <= {uart_rxd_i, rx_shift[7:1]};
            rx_nbit  <= rx_nbit + 1'b1;
            if (rx_nbit == `UART_LAST_DATA)
              rx_state <= RX_STOP;
          end
        end
        RX_STOP: begin
          // only the first stop is waited for; the second is idle line
          rx_cnt <= rx_cnt + 1'b1;
          if (rx_cnt == bit_cycles - 1'b1) begin
            rx_evt   <= 1'b1;
            rx_state <= RX_IDLE;
          end
        end
        default: rx_state <= RX_BAUD;
      endcase
    end
  end

  // one character of slack between receiver and parser
  logic       char_valid;
  logic [7:0] char_q;
  logic       out_pend;
  logic       take;
  assign take = char_valid & ~out_pend;
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      char_valid <= 1'b0;
      char_q     <= 8'h00;
      overrun_o  <= 1'b0;
    end else begin
      if (rx_evt) begin
        char_valid <= 1'b1;
        char_q     <= rx_shift;
      end else if (take)
        char_valid <= 1'b0;
      if (rx_evt && char_valid && !take)
        overrun_o <= 1'b1; // sticky until srst; the host outran a stalled drain
    end
  end

  // frame parser
  parse_state_t pstate;
  logic         hi_done;
  logic [3:0]   hi_nib;
  logic [7:0]   rec_len;
  logic [7:0]   rec_idx;
  logic [7:0]   rec_sum;
  logic [15:0]  rec_ofs;
  logic [7:0]   rec_type;
  prog_word_t   out_word;
  logic [4:0]   hv;
  logic [7:0]   byte_in;
  logic         push;
  logic [1:0]   err_cnt;
  logic         tx_go_err;
  assign hv      = hex_val(char_q);
  assign byte_in = {hi_nib, hv[3:0]};
  always_ff @(posedge core_clk_i) begin
    if (srst_i || !loader_active) begin
      pstate        <= PS_IDLE;
      hi_done       <= 1'b0;
      hi_nib        <= 4'h0;
      rec_len       <= 8'h00;
      rec_idx       <= 8'h00;
      rec_sum       <= 8'h00;
      rec_ofs       <= 16'h0000;
      rec_type      <= 8'h00;
      out_pend      <= 1'b0;
      out_word      <= '0;
      frame_done_o  <= 1'b0;
      frame_error_o <= 1'b0;
    end else begin
      frame_done_o  <= 1'b0;
      frame_error_o <= 1'b0;
      if (push)
        out_pend <= 1'b0;
      if (take) begin
        if (char_q == `CH_COLON) begin
          pstate  <= PS_LEN;
          hi_done <= 1'b0;
          rec_sum <= 8'h00;
        end else if (pstate == PS_IDLE) begin
          hi_done <= 1'b0;
        end else if (!hv[4]) begin
          pstate <= PS_IDLE; // stray character aborts the frame
        end else if (!hi_done) begin
          hi_nib  <= hv[3:0];
          hi_done <= 1'b1;
        end else begin
          hi_done <= 1'b0;
          rec_sum <= rec_sum + byte_in;
          case (pstate)
            PS_LEN: begin
              rec_len <= byte_in;
              pstate  <= PS_OFS_HI;
            end
            PS_OFS_HI: begin
              rec_ofs[15:8] <= byte_in;
              pstate        <= PS_OFS_LO;
            end
            PS_OFS_LO: begin
              rec_ofs[7:0] <= byte_in;
              pstate       <= PS_TYPE;
            end
            PS_TYPE: begin
              rec_type <= byte_in;
              rec_idx  <= 8'h00;
              pstate   <= (rec_len == 8'h00) ? PS_SUM : PS_DATA;
            end
            PS_DATA: begin
              // bytes leave before the checksum is known; consumer discards on frame_error_o
              out_word.rtype <= rec_type;
              out_word.data  <= byte_in;
              out_word.addr  <= (rec_type == `REC_DATA_PROGRAM) ? rec_ofs + {8'h00, rec_idx} : 16'h0000;
              out_pend <= !((rec_type == `REC_DATA_PROGRAM) && sw_lock_o.loader_prog_block);
              rec_idx  <= rec_idx + 1'b1;
              if (rec_idx == rec_len - 1'b1)
                pstate <= PS_SUM;
            end
            PS_SUM: begin
              frame_done_o  <= 1'b1;
              frame_error_o <= (rec_sum + byte_in) != 8'h00;
              pstate        <= PS_IDLE;
            end
            default: pstate <= PS_IDLE;
          endcase
        end
      end
    end
  end

  // two-entry buffer toward the flash writer; a full buffer stalls the parser
  prog_word_t       mem [DEPTH];
  logic [PTR_W-1:0] wp;
  logic [PTR_W-1:0] rp;
  logic [PTR_W:0]   fill;
  logic             in_ready;
  logic             pop;
  assign in_ready     = (fill != DEPTH[PTR_W:0]);
  assign push         = out_pend & in_ready;
  assign word_valid_o = (fill != '0);
  assign pop          = word_valid_o & word_ready_i;
  assign word_o       = mem[rp];
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      wp   <= '0;
      rp   <= '0;
      fill <= '0;
    end else begin
      if (push) begin
        mem[wp] <= out_word;
        wp      <= (wp == PTR_W'(DEPTH - 1)) ? '0 : wp + 1'b1;
      end
      if (pop)
        rp <= (rp == PTR_W'(DEPTH - 1)) ? '0 : rp + 1'b1;
      fill <= fill + {{PTR_W{1'b0}}, push} - {{PTR_W{1'b0}}, pop};
    end
  end

  // transmitter: echo first, then the error trailer
  logic             echo_pend;
  logic [7:0]       echo_char;
  logic             tx_busy;
  logic [10:0]      tx_shift;
  logic [3:0]       tx_bits;
  logic [CNT_W-1:0] tx_cnt;
  logic             tx_start;
  logic [7:0]       err_char;
  assign tx_start  = ~tx_busy & (echo_pend | (err_cnt != 2'h0));
  assign tx_go_err = tx_start & ~echo_pend;
  assign err_char  = (err_cnt == `ERR_SEQ_LEN) ? `CH_X : (err_cnt == 2'h2) ? `CH_CR : `CH_LF;
  always_ff @(posedge core_clk_i) begin
    if (srst_i || !loader_active) begin
      echo_pend <= 1'b0;
      echo_char <= 8'h00;
      err_cnt   <= 2'h0;
    end else begin
      if (rx_evt) begin
        echo_pend <= 1'b1; // a new character wins over the clear
        echo_char <= rx_shift;
      end else if (tx_start)
        echo_pend <= 1'b0;
      if (frame_error_o)
        err_cnt <= `ERR_SEQ_LEN;
      else if (tx_go_err)
        err_cnt <= err_cnt - 1'b1;
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (srst_i || !loader_active) begin
      tx_busy  <= 1'b0;
      tx_shift <= 11'h7ff;
      tx_bits  <= 4'h0;
      tx_cnt   <= '0;
    end else if (tx_start) begin
      tx_busy  <= 1'b1;
      tx_shift <= {2'b11, echo_pend ? echo_char : err_char, 1'b0};
      tx_bits  <= `UART_FRAME_BITS;
      tx_cnt   <= '0;
    end else if (tx_busy) begin
      tx_cnt <= tx_cnt + 1'b1;
      if (tx_cnt == bit_cycles - 1'b1) begin
        tx_cnt   <= '0;
        tx_shift <= {1'b1, tx_shift[10:1]};
        tx_bits  <= tx_bits - 1'b1;
        tx_busy  <= (tx_bits != 4'h1);
      end
    end
  end
  assign uart_txd_o = tx_busy ? tx_shift[0] : 1'b1;

  // checks
  property p_force_rom;
    @(posedge core_clk_i) disable iff (srst_i)
    release_edge && !boot_force_strobe_pin_i |=> boot_mode_o == BOOT_ROM && boot_addr_o == 16'hf800;
  endproperty
  a_force_rom: assert property (p_force_rom) else $error("forced boot did not pick rom loader");
  property p_app_jump;
    @(posedge core_clk_i) disable iff (srst_i)
    release_edge && boot_force_strobe_pin_i && boot_jump_fuse_i |=> boot_mode_o == BOOT_APP && boot_addr_o == 16'h0000;
  endproperty
  a_app_jump: assert property (p_app_jump) else $error("jump fuse did not start application");
  property p_customer;
    @(posedge core_clk_i) disable iff (srst_i)
    boot_valid_o && boot_mode_o == BOOT_CUSTOMER |-> boot_addr_o[7:0] == 8'h00 && boot_addr_o[15:8] != 8'hfc;
  endproperty
  a_customer: assert property (p_customer) else $error("customer loader address malformed");
  property p_only_edge;
    @(posedge core_clk_i) disable iff (srst_i)
    $rose(boot_valid_o) |-> $past(rst_act_q) && !$past(rst_active);
  endproperty
  a_only_edge: assert property (p_only_edge) else $error("boot decided away from release edge");
  property p_shadow;
    @(posedge core_clk_i) disable iff (srst_i)
    release_edge |=> shadow[6] == $past(boot_jump_fuse_i) && shadow[2:0] == $past(hardware_lock_bits_i) && !shadow[4];
  endproperty
  a_shadow: assert property (p_shadow) else $error("shadow byte does not mirror fuses");
  property p_lock_levels;
    @(posedge core_clk_i) disable iff (srst_i)
    !shadow[2] |-> hw_lock_o == 3'b111 && (internal_fetch_allow_o != code_read_from_ext_i);
  endproperty
  a_lock_levels: assert property (p_lock_levels) else $error("level 4 restrictions missing");
  property p_sw_open;
    @(posedge core_clk_i) disable iff (srst_i)
    sw_lock[1:0] == 2'b11 |-> sw_lock_o == 2'b00;
  endproperty
  a_sw_open: assert property (p_sw_open) else $error("open software lock blocks loader");
  property p_colon;
    @(posedge core_clk_i) disable iff (srst_i || !loader_active)
    take && char_q == 8'h3a |=> pstate == PS_LEN && !hi_done && rec_sum == 8'h00;
  endproperty
  a_colon: assert property (p_colon) else $error("colon did not restart the frame");
  property p_offset;
    @(posedge core_clk_i) disable iff (srst_i)
    push && out_word.rtype != 8'h00 |-> out_word.addr == 16'h0000;
  endproperty
  a_offset: assert property (p_offset) else $error("offset used for non-program record");
  property p_err_trailer;
    @(posedge core_clk_i) disable iff (srst_i || !loader_active)
    frame_error_o |=> err_cnt == 2'h3;
  endproperty
  a_err_trailer: assert property (p_err_trailer) else $error("checksum error trailer not queued");
  property p_echo;
    @(posedge core_clk_i) disable iff (srst_i || !loader_active)
    rx_evt |=> echo_pend && echo_char == $past(rx_shift);
  endproperty
  a_echo: assert property (p_echo) else $error("received character not queued for echo");
  c_rom_boot: cover property (@(posedge core_clk_i) disable iff (srst_i) $rose(boot_valid_o) && boot_mode_o == BOOT_ROM);
  c_frame_ok: cover property (@(posedge core_clk_i) disable iff (srst_i) frame_done_o && !frame_error_o);
  c_buf_full: cover property (@(posedge core_clk_i) disable iff (srst_i) out_pend && !in_ready);
endmodule : boot_select_isp_frame

// File: verilog/boot_select_params.svh
`ifndef BOOT_SELECT_PARAMS_SVH
`define BOOT_SELECT_PARAMS_SVH
// entry addresses and boot bytes
`define ROM_LOADER_ADDR    16'hf800
`define APP_START_ADDR     16'h0000
`define SOFT_VEC_NONE      8'hfc
`define SOFT_VEC_LOW       8'h00
`define BOOT_STATUS_APP    8'h00
// software lock byte
`define SW_LOCK_RESET      8'hff
`define SW_LOCK_RSVD       8'hfc
`define SW_LOCK_B0         0
`define SW_LOCK_B1         1
// shadow byte layout
`define SHADOW_RESET       8'hef
`define SHADOW_DBL_BIT     7
`define SHADOW_JUMP_BIT    6
`define SHADOW_SRC_BIT     5
`define SHADOW_RSVD_BIT    4
`define SHADOW_RAM_BIT     3
`define HW_LOCK_B0         0
`define HW_LOCK_B1         1
`define HW_LOCK_B2         2
// frame characters
`define REC_DATA_PROGRAM   8'h00
`define CH_COLON           8'h3a
`define CH_X               8'h58
`define CH_CR              8'h0d
`define CH_LF              8'h0a
`define CH_DIG_0           8'h30
`define CH_DIG_9           8'h39
`define CH_UP_A            8'h41
`define CH_UP_F            8'h46
`define CH_LO_A            8'h61
`define CH_LO_F            8'h66
`define HEX_ALPHA_ADJ      4'h9
// serial character: start, 8 data, 2 stop
`define UART_LAST_DATA     3'h7
`define UART_FRAME_BITS    4'hb
`define ERR_SEQ_LEN        2'h3
`endif

// File: verilog/boot_select_pkg.sv
package boot_select_pkg;
  typedef enum logic [1:0] {
    BOOT_NONE     = 2'b00,
    BOOT_ROM      = 2'b01,
    BOOT_CUSTOMER = 2'b10,
    BOOT_APP      = 2'b11
  } boot_mode_t;
  typedef enum logic [2:0] {
    PS_IDLE   = 3'b000,
    PS_LEN    = 3'b001,
    PS_OFS_HI = 3'b010,
    PS_OFS_LO = 3'b011,
    PS_TYPE   = 3'b100,
    PS_DATA   = 3'b101,
    PS_SUM    = 3'b110
  } parse_state_t;
  typedef enum logic [2:0] {
    RX_BAUD  = 3'b000,
    RX_IDLE  = 3'b001,
    RX_START = 3'b010,
    RX_BITS  = 3'b011,
    RX_STOP  = 3'b100
  } rx_state_t;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  rtype;
    logic [7:0]  data;
  } prog_word_t;
  typedef struct packed {
    logic parallel_prog_block;
    logic parallel_verify_block;
    logic external_exec_block;
  } hw_lock_t;
  typedef struct packed {
    logic loader_prog_block;
    logic loader_verify_block;
  } sw_lock_t;
endpackage : boot_select_pkg
